// File: afsf_mem_if.sv
// Purpose: write and read port bundle between fifo control and store
// Assumes: one clock, write lands at the edge, read is combinational
// Notes: ctl drives addresses and write word, mem returns the read word
`timescale 1ns/1ps
interface afsf_mem_if;
	import afsf_pkg::*;
	logic we; // store the write word this edge
	logic [PTR_W-1:0] waddr; // write index
	afsf_word_t wword; // word to store
	logic [PTR_W-1:0] raddr; // read index
	afsf_word_t rword; // word at read index
	modport ctl (output we, output waddr, output wword, output raddr, input rword);
	modport mem (input we, input waddr, input wword, input raddr, output rword);
endinterface

// File: afsf_pkg.sv
// Purpose: shared constants and types of the stream fifo with sideband flags
// Assumes: one clock, 64-bit payload, 16-word store, apb register window
// Notes: the stored word is the ecc code word plus the sideband fields
package afsf_pkg;
	// ----------------------------------------------------------------
	// stream and store geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 64; // payload bits
	localparam int KEEP_W = DATA_W / 8; // one keep bit per byte
	localparam int ID_W = 4; // stream identifier bits
	localparam int DEST_W = 4; // routing bits
	localparam int USER_W = 4; // user sideband bits
	localparam int DEPTH = 16; // stored words
	localparam int PTR_W = 4; // log2 of depth
	localparam int CNT_W = PTR_W + 1; // count reaches depth itself
	localparam int THR_W = PTR_W; // threshold bus width
	localparam int HAM_W = 7; // hamming check bits
	localparam int CODE_W = DATA_W + HAM_W + 1; // plus overall parity
	localparam int INJ_POS_A = 3; // first flipped code bit on injection
	localparam int INJ_POS_B = 5; // second flipped code bit, double only
	localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10; // count when full
	// ----------------------------------------------------------------
	// register window
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8; // decoded address bits
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00; // option enables
	localparam logic [ADDR_W-1:0] REG_STAT = 8'h04; // live fifo state
	localparam logic [ADDR_W-1:0] REG_IRQ = 8'h08; // sticky events, write one clears
	localparam logic [ADDR_W-1:0] REG_MASK = 8'h0C; // event enables
	localparam logic [ADDR_W-1:0] REG_THR = 8'h10; // captured thresholds
	localparam int CTRL_W = 3; // control bits
	localparam int CTRL_PF = 0; // programmable full enable
	localparam int CTRL_PE = 1; // programmable empty enable
	localparam int CTRL_ECC = 2; // ecc enable
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h7; // all options on
	localparam int IRQ_W = 4; // event bits
	localparam int IRQ_SBE = 0; // corrected error seen
	localparam int IRQ_DBE = 1; // uncorrectable error seen
	localparam int IRQ_OVF = 2; // rejected write
	localparam int IRQ_PF = 3; // programmable full rose
	localparam logic [IRQ_W-1:0] MASK_RST = 4'h0; // all masked
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [KEEP_W-1:0] keep;
		logic last;
		logic [ID_W-1:0] id;
		logic [DEST_W-1:0] dest;
		logic [USER_W-1:0] user;
	} afsf_side_t;
	typedef struct packed {
		afsf_side_t side;
		logic [CODE_W-1:0] code;
	} afsf_word_t;
	typedef struct packed {
		logic pe;
		logic pf;
		logic empty;
		logic full;
		logic [CNT_W-1:0] cnt;
	} afsf_stat_t;
endpackage

// File: afsf_secded.sv
// Purpose: single-correct double-detect code for the payload
// Assumes: caller gates injection with the ecc enable
// Notes: bit 0 is overall parity, bits 1..71 are hamming positions
`timescale 1ns/1ps
module afsf_secded
	import afsf_pkg::*;
(
	// clock and reset, only for the checks
	input wire logic clk_sys,
	input wire logic rst,
	// encoder side
	input wire logic [DATA_W-1:0] enc_data,
	input wire logic inj_single,
	input wire logic inj_double,
	output logic [CODE_W-1:0] enc_code,
	// decoder side
	input wire logic [CODE_W-1:0] dec_code,
	output logic [DATA_W-1:0] dec_data,
	output logic dec_sbe,
	output logic dec_dbe
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// xor of the positions of all set hamming bits
	function automatic logic [HAM_W-1:0] syndrome(input logic [CODE_W-1:0] c);
		logic [HAM_W-1:0] s;
		s = '0;
		for (int p = 1; p < CODE_W; p++) begin
			if (c[p]) begin
				s = s ^ HAM_W'(p);
			end
		end
		return s;
	endfunction
	// payload sits at every position that is not a power of two
	function automatic logic [DATA_W-1:0] extract(input logic [CODE_W-1:0] c);
		logic [DATA_W-1:0] d;
		int k;
		d = '0;
		k = 0;
		for (int p = 1; p < CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = c[p];
				k++;
			end
		end
		return d;
	endfunction
	logic [CODE_W-1:0] clean_code; // code before injection
	logic [HAM_W-1:0] syn; // decoder syndrome
	logic odd; // overall parity mismatch
	// ----------------------------------------------------------------
	// encoder with test injection
	// ----------------------------------------------------------------
	always_comb begin
		int k;
		logic [HAM_W-1:0] s;
		k = 0;
		s = '0;
		clean_code = '0;
		for (int p = 1; p < CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				clean_code[p] = enc_data[k];
				k++;
			end
		end
		s = syndrome(clean_code);
		for (int i = 0; i < HAM_W; i++) begin
			clean_code[1 << i] = s[i];
		end
		clean_code[0] = ^clean_code;
		enc_code = clean_code;
		if (inj_single || inj_double) begin
			enc_code[INJ_POS_A] = ~clean_code[INJ_POS_A]; // RULE8
		end
		if (inj_double) begin
			enc_code[INJ_POS_B] = ~clean_code[INJ_POS_B]; // RULE9
		end
	end
	// ----------------------------------------------------------------
	// decoder: a syndrome past the last position can only be a multi-bit hit
	// ----------------------------------------------------------------
	always_comb begin
		logic [CODE_W-1:0] fixed;
		fixed = dec_code;
		syn = syndrome(dec_code);
		odd = ^dec_code;
		dec_sbe = 1'b0;
		dec_dbe = 1'b0;
		if (odd && (int'(syn) < CODE_W)) begin
			fixed[syn] = ~dec_code[syn]; // syndrome zero fixes the parity bit
			dec_sbe = 1'b1; // RULE10
		end else if (syn != '0) begin
			dec_dbe = 1'b1; // RULE11
		end
		dec_data = extract(fixed);
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	single_inject_a: assert property ( // RULE8
		inj_single && !inj_double |-> $countones(enc_code ^ clean_code) == 1)
		else $error("single injection did not flip one bit");
	double_inject_a: assert property ( // RULE9
		inj_double |-> $countones(enc_code ^ clean_code) == 2)
		else $error("double injection did not flip two bits");
endmodule

// File: afsf_sink.sv
// Purpose: downstream stream sink that paces ready and keeps every beat it takes
// Assumes: shares clk_sys with the fifo
// Notes: mode 0 stalls, 1 always ready, 2 ready every other cycle
`timescale 1ns/1ps
module afsf_sink
	import afsf_pkg::*;
(
	// clock and pace
	input wire logic clk_sys,
	input wire logic [1:0] mode,
	// stream from the fifo
	input wire logic tvalid,
	output logic tready,
	input wire logic [86:0] beat
);
	logic [86:0] got[$]; // taken beats, oldest first, null bytes kept as seen
	initial tready = 1'h0;
	// capture at the taking edge, then move ready; slow mode halves the rate
	always @(posedge clk_sys) begin
		if (tvalid === 1'h1 && tready === 1'h1) got.push_back(beat);
		tready <= (mode == 2'h1) || (mode == 2'h2 && !tready);
	end
endmodule

// File: afsf_store.sv
// Purpose: flip-flop word store indexed by pointer
// Assumes: write and read never need a bypass, control keeps them apart
// Notes: no reset on the array, contents are only read once written
`timescale 1ns/1ps
module afsf_store
	import afsf_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// port bundle
	afsf_mem_if.mem mp
);
	afsf_word_t mem_reg [DEPTH]; // storage array
	// ----------------------------------------------------------------
	// write, only on an accepted word so a refused one leaves all intact
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (mp.we) begin
			mem_reg[mp.waddr] <= mp.wword; // RULE13
		end
	end
	// read is a plain mux so the output stage can load in one edge
	assign mp.rword = mem_reg[mp.raddr];
endmodule

// File: afsf_top.sv
// Purpose: stream fifo with stored sideband, thresholds, ecc and apb status
// Assumes: upstream and downstream stream logic share clk_sys with this block
// Notes: thresholds come from pins and are captured once per reset
//
// How it works
// RULE1: keep bit n qualifies payload byte n
// RULE2: keep bits pass untouched so nulls droppable
// RULE3: last flag marks packet closing transfer
// RULE4: id, dest, user leave with their word
// RULE5: full threshold taken from its input bus
// RULE6: empty threshold taken from its own bus
// RULE7: thresholds change only in reset, captured there
// RULE8: single injection corrupts one stored bit
// RULE9: double injection corrupts two stored bits
// RULE10: corrected single error raises its flag
// RULE11: uncorrectable double error raises its flag
// RULE12: overflow flags a refused write next cycle
// RULE13: refused write leaves contents and pointers
// RULE14: full refuses writes, so overflow stays low
// RULE15: prog full while count at least threshold
// RULE16: prog empty while count at most threshold
// RULE17: sideband stored with word, same order out
`timescale 1ns/1ps
module afsf_top
	import afsf_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// stream in
	input wire logic s_axis_tvalid,
	output logic s_axis_tready,
	input wire logic [DATA_W-1:0] s_axis_tdata,
	input wire logic [KEEP_W-1:0] s_axis_tkeep,
	input wire logic s_axis_tlast,
	input wire logic [ID_W-1:0] s_axis_tid,
	input wire logic [DEST_W-1:0] s_axis_tdest,
	input wire logic [USER_W-1:0] s_axis_tuser,
	// stream out
	output logic m_axis_tvalid,
	input wire logic m_axis_tready,
	output logic [DATA_W-1:0] m_axis_tdata,
	output logic [KEEP_W-1:0] m_axis_tkeep,
	output logic m_axis_tlast,
	output logic [ID_W-1:0] m_axis_tid,
	output logic [DEST_W-1:0] m_axis_tdest,
	output logic [USER_W-1:0] m_axis_tuser,
	// thresholds and injection
	input wire logic [THR_W-1:0] prog_full_thresh,
	input wire logic [THR_W-1:0] prog_empty_thresh,
	input wire logic inject_sbit,
	input wire logic inject_dbit,
	// flags
	output logic sbit_err,
	output logic dbit_err,
	output logic overflow,
	output logic prog_full,
	output logic prog_empty,
	output logic irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	afsf_mem_if mp (); // store port bundle
	logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next; // write index
	logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next; // read index
	logic [CNT_W-1:0] cnt_reg, cnt_next; // words in the store
	logic tready_reg, tready_next; // room for one more
	logic wr_go, rd_go; // accepted write, load of output stage
	logic m_valid_reg, m_valid_next; // output stage holds a word
	logic [DATA_W-1:0] m_data_reg, m_data_next; // output payload
	afsf_side_t m_side_reg, m_side_next; // output sideband
	logic sbe_reg, sbe_next, dbe_reg, dbe_next; // flags of the held word
	logic ovf_reg, ovf_next; // refused write seen
	logic pf_reg, pf_next, pe_reg, pe_next; // threshold flags
	logic [THR_W-1:0] pf_meta_reg, pf_sync_reg, pe_meta_reg, pe_sync_reg; // pin sync
	logic [THR_W-1:0] pf_thr_reg, pf_thr_next, pe_thr_reg, pe_thr_next; // captured
	logic cap_pend_reg, cap_pend_next; // capture due after reset release
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next; // option enables
	logic [IRQ_W-1:0] ist_reg, ist_next, mask_reg, mask_next; // events and mask
	logic [IRQ_W-1:0] evt; // this cycle's events
	logic irq_reg, irq_next; // interrupt level
	logic [31:0] prdata_reg, prdata_next; // read answer
	logic pready_reg, pready_next, perr_reg, perr_next; // apb answer
	logic acc_take, mapped; // apb access completes, address decodes
	logic [CODE_W-1:0] enc_code; // encoded write word
	logic [DATA_W-1:0] dec_data; // corrected read payload
	logic dec_sbe, dec_dbe; // decoder findings
	logic ecc_on; // ecc option
	afsf_stat_t stat; // status view
	// ----------------------------------------------------------------
	// ecc codec and store
	// ----------------------------------------------------------------
	assign ecc_on = ctrl_reg[CTRL_ECC];
	afsf_secded u_ecc (
		.clk_sys(clk_sys),
		.rst(rst),
		.enc_data(s_axis_tdata),
		.inj_single(inject_sbit && ecc_on), // RULE8
		.inj_double(inject_dbit && ecc_on), // RULE9
		.enc_code(enc_code),
		.dec_code(mp.rword.code),
		.dec_data(dec_data),
		.dec_sbe(dec_sbe),
		.dec_dbe(dec_dbe)
	);
	afsf_store u_store (
		.clk_sys(clk_sys),
		.mp(mp)
	);
	// ----------------------------------------------------------------
	// threshold pins: two-flop sync, free running so reset-time level settles
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		pf_meta_reg <= prog_full_thresh;
		pf_sync_reg <= pf_meta_reg;
		pe_meta_reg <= prog_empty_thresh;
		pe_sync_reg <= pe_meta_reg;
	end
	// ----------------------------------------------------------------
	// fifo control: next values
	// ----------------------------------------------------------------
	always_comb begin
		wr_go = s_axis_tvalid && tready_reg; // full never accepts
		rd_go = (cnt_reg != '0) && (!m_valid_reg || m_axis_tready);
		wr_ptr_next = wr_go ? wr_ptr_reg + PTR_W'(1) : wr_ptr_reg; // RULE13
		rd_ptr_next = rd_go ? rd_ptr_reg + PTR_W'(1) : rd_ptr_reg;
		cnt_next = cnt_reg + CNT_W'(wr_go) - CNT_W'(rd_go);
		tready_next = (cnt_next != DEPTH_CNT); // RULE14
		// the handshake leaves no refused write, so this stays low
		ovf_next = 1'b0; // RULE12 RULE14
		// keep, last, id, dest, user ride in the same stored word
		mp.we = wr_go;
		mp.waddr = wr_ptr_reg;
		mp.wword.code = enc_code;
		mp.wword.side.keep = s_axis_tkeep; // RULE1 RULE2 RULE17
		mp.wword.side.last = s_axis_tlast; // RULE3
		mp.wword.side.id = s_axis_tid; // RULE4
		mp.wword.side.dest = s_axis_tdest;
		mp.wword.side.user = s_axis_tuser;
		mp.raddr = rd_ptr_reg;
		// output stage: load, hand over, or hold
		m_valid_next = m_valid_reg;
		m_data_next = m_data_reg;
		m_side_next = m_side_reg;
		sbe_next = sbe_reg;
		dbe_next = dbe_reg;
		if (rd_go) begin
			m_valid_next = 1'b1;
			m_data_next = dec_data;
			m_side_next = mp.rword.side; // RULE4 RULE17
			sbe_next = dec_sbe && ecc_on; // RULE10
			dbe_next = dec_dbe && ecc_on; // RULE11
		end else if (m_axis_tready) begin
			m_valid_next = 1'b0;
			sbe_next = 1'b0;
			dbe_next = 1'b0;
		end
		// capture once at the first edge after release
		pf_thr_next = cap_pend_reg ? pf_sync_reg : pf_thr_reg; // RULE5 RULE7
		pe_thr_next = cap_pend_reg ? pe_sync_reg : pe_thr_reg; // RULE6 RULE7
		cap_pend_next = 1'b0;
		// flags use the threshold in force after this edge, so no false pulse at capture
		pf_next = ctrl_reg[CTRL_PF] && (cnt_next >= {1'b0, pf_thr_next}); // RULE15
		pe_next = ctrl_reg[CTRL_PE] && (cnt_next <= {1'b0, pe_thr_next}); // RULE16
	end
	// fifo control: registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			tready_reg <= 1'b0;
			m_valid_reg <= 1'b0;
			m_data_reg <= '0;
			m_side_reg <= '0;
			sbe_reg <= 1'b0;
			dbe_reg <= 1'b0;
			ovf_reg <= 1'b0;
			pf_reg <= 1'b0;
			pe_reg <= 1'b0;
			pf_thr_reg <= '0;
			pe_thr_reg <= '0;
			cap_pend_reg <= 1'b1;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg <= cnt_next;
			tready_reg <= tready_next;
			m_valid_reg <= m_valid_next;
			m_data_reg <= m_data_next;
			m_side_reg <= m_side_next;
			sbe_reg <= sbe_next;
			dbe_reg <= dbe_next;
			ovf_reg <= ovf_next;
			pf_reg <= pf_next;
			pe_reg <= pe_next;
			pf_thr_reg <= pf_thr_next;
			pe_thr_reg <= pe_thr_next;
			cap_pend_reg <= cap_pend_next;
		end
	end
	// ----------------------------------------------------------------
	// apb slave and interrupt: next values
	// ----------------------------------------------------------------
	// answer comes one cycle into the access phase, so prdata is a flop
	always_comb begin
		acc_take = psel && penable && pready_reg;
		mapped = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_IRQ)
			|| (paddr == REG_MASK) || (paddr == REG_THR);
		pready_next = psel && penable && !pready_reg;
		perr_next = pready_next && !mapped;
		stat.pe = pe_reg;
		stat.pf = pf_reg;
		stat.empty = (cnt_reg == '0);
		stat.full = !tready_reg;
		stat.cnt = cnt_reg;
		prdata_next = '0;
		if (pready_next && !pwrite) begin
			case (paddr)
				REG_CTRL: prdata_next = 32'(ctrl_reg);
				REG_STAT: prdata_next = 32'(stat);
				REG_IRQ: prdata_next = 32'(ist_reg);
				REG_MASK: prdata_next = 32'(mask_reg);
				REG_THR: prdata_next = 32'({pe_thr_reg, pf_thr_reg});
				default: prdata_next = '0; // unmapped reads zero
			endcase
		end
		evt = '0;
		evt[IRQ_SBE] = rd_go && dec_sbe && ecc_on;
		evt[IRQ_DBE] = rd_go && dec_dbe && ecc_on;
		evt[IRQ_OVF] = ovf_reg;
		evt[IRQ_PF] = pf_next && !pf_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		ist_next = ist_reg;
		if (acc_take && pwrite) begin
			case (paddr)
				REG_CTRL: ctrl_next = pwdata[CTRL_W-1:0];
				REG_MASK: mask_next = pwdata[IRQ_W-1:0];
				REG_IRQ: ist_next = ist_reg & ~pwdata[IRQ_W-1:0];
				default: ist_next = ist_reg; // read-only or unmapped
			endcase
		end
		// a new event wins over a clear in the same cycle
		ist_next = ist_next | evt;
		irq_next = |(ist_next & mask_next);
	end
	// apb slave and interrupt: registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RST;
			mask_reg <= MASK_RST;
			ist_reg <= '0;
			irq_reg <= 1'b0;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			perr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			ist_reg <= ist_next;
			irq_reg <= irq_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			perr_reg <= perr_next;
		end
	end
	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = perr_reg;
	assign s_axis_tready = tready_reg;
	assign m_axis_tvalid = m_valid_reg;
	assign m_axis_tdata = m_data_reg;
	assign m_axis_tkeep = m_side_reg.keep;
	assign m_axis_tlast = m_side_reg.last;
	assign m_axis_tid = m_side_reg.id;
	assign m_axis_tdest = m_side_reg.dest;
	assign m_axis_tuser = m_side_reg.user;
	assign sbit_err = sbe_reg;
	assign dbit_err = dbe_reg;
	assign overflow = ovf_reg;
	assign prog_full = pf_reg;
	assign prog_empty = pe_reg;
	assign irq = irq_reg;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	keep_hold_a: assert property ( // RULE1
		m_valid_reg && !m_axis_tready |=> m_valid_reg && $stable(m_axis_tkeep)
		&& $stable(m_axis_tdata)) else $error("keep or data moved while stalled");
	last_hold_a: assert property ( // RULE3
		m_valid_reg && !m_axis_tready |=> $stable(m_axis_tlast))
		else $error("last moved while stalled");
	side_hold_a: assert property ( // RULE4
		m_valid_reg && !m_axis_tready |=> $stable({m_axis_tid, m_axis_tdest, m_axis_tuser}))
		else $error("sideband moved while stalled");
	full_refuse_a: assert property (cnt_reg == DEPTH_CNT |-> !s_axis_tready) // RULE14
		else $error("ready while full");
	count_bound_a: assert property (cnt_reg <= DEPTH_CNT && !overflow) // RULE13
		else $error("count past depth or overflow");
	// the reset-time flag is not a threshold compare, so the capture cycle is left out
	pfull_level_a: assert property ( // RULE15
		!cap_pend_reg && ctrl_reg[CTRL_PF] && $stable(ctrl_reg) && $stable(pf_thr_reg) |->
		prog_full == (cnt_reg >= {1'b0, pf_thr_reg})) else $error("prog full off its threshold");
	pempty_level_a: assert property ( // RULE16
		!cap_pend_reg && ctrl_reg[CTRL_PE] && $stable(ctrl_reg) && $stable(pe_thr_reg) |->
		prog_empty == (cnt_reg <= {1'b0, pe_thr_reg})) else $error("prog empty off its threshold");
	thr_full_a: assert property ( // RULE5
		$fell(cap_pend_reg) |-> pf_thr_reg == $past(pf_sync_reg))
		else $error("full threshold not captured");
	thr_empty_a: assert property ( // RULE6
		$fell(cap_pend_reg) |-> pe_thr_reg == $past(pe_sync_reg) ##1 $stable(pe_thr_reg)[*4])
		else $error("empty threshold not held");
	sbe_flag_a: assert property ( // RULE10
		rd_go && dec_sbe && ecc_on |=> sbit_err && m_axis_tvalid && !dbit_err)
		else $error("corrected error not flagged");
	dbe_flag_a: assert property ( // RULE11
		rd_go && dec_dbe && ecc_on |=> dbit_err && m_axis_tvalid ##1 ist_reg[IRQ_DBE])
		else $error("double error not flagged");
endmodule

// File: tb_top.sv
// Purpose: self-checking bench for the stream fifo with sideband flags
// Assumes: thresholds only move while rst is high
// Notes: apb reads, stalled fills to full, ecc injection, irq mask and clear
`timescale 1ns/1ps
module tb_top
	import afsf_pkg::*;
;
	logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
	logic [ADDR_W-1:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd; // rd holds prdata of the last access
	logic pready, pslverr, s_axis_tready, m_axis_tvalid, m_axis_tready, m_axis_tlast;
	logic s_axis_tvalid = 1'h0, s_axis_tlast = 1'h0, inject_sbit = 1'h0, inject_dbit = 1'h0;
	logic [DATA_W-1:0] s_axis_tdata = 64'h0, m_axis_tdata;
	logic [KEEP_W-1:0] s_axis_tkeep = 8'h0, m_axis_tkeep;
	logic [3:0] s_axis_tid = 4'h0, s_axis_tdest = 4'h0, s_axis_tuser = 4'h0;
	logic [3:0] m_axis_tid, m_axis_tdest, m_axis_tuser;
	logic [THR_W-1:0] prog_full_thresh = 4'hC, prog_empty_thresh = 4'h2;
	logic sbit_err, dbit_err, overflow, prog_full, prog_empty, irq;
	logic [1:0] mode = 2'h0; // sink pace
	logic [86:0] w;
	int err_total = 0, samples_checked = 0, cyc = 0;
	afsf_top DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .s_axis_tvalid, .s_axis_tready, .s_axis_tdata, .s_axis_tkeep, .s_axis_tlast,
		.s_axis_tid, .s_axis_tdest, .s_axis_tuser, .m_axis_tvalid, .m_axis_tready,
		.m_axis_tdata, .m_axis_tkeep, .m_axis_tlast, .m_axis_tid, .m_axis_tdest, .m_axis_tuser,
		.prog_full_thresh, .prog_empty_thresh, .inject_sbit, .inject_dbit, .sbit_err,
		.dbit_err, .overflow, .prog_full, .prog_empty, .irq);
	afsf_sink sink (.clk_sys, .mode, .tvalid(m_axis_tvalid), .tready(m_axis_tready),
		.beat({sbit_err, dbit_err, m_axis_tkeep, m_axis_tlast, m_axis_tid, m_axis_tdest,
		m_axis_tuser, m_axis_tdata}));
	initial forever #12.5 clk_sys = ~clk_sys;
	// beat i: flags, a rolling null byte, last every fourth, id, dest, user from the low nibble of i
	function automatic logic [86:0] exp_beat(int i, logic sb, logic db);
		logic [7:0] b;
		b = i[7:0];
		return {sb, db, ~(8'h01 << i[2:0]), i[1:0] == 2'h3, b[3:0], ~b[3:0], b[3:0] + 4'h1,
			{8{b}} ^ 64'h0123456789ABCDEF};
	endfunction
	task automatic chk(string n, logic [86:0] s, logic [86:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// apb master: setup, access until pready, release after the taking edge
	task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rchk(string n, logic [ADDR_W-1:0] a, logic [32:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, {er, rd}, e);
	endtask
	// one beat, held until the edge that takes it
	task automatic push(int i, logic sb, logic db);
		logic [86:0] v;
		v = exp_beat(i, sb, db);
		@(posedge clk_sys);
		s_axis_tvalid <= 1'h1;
		{s_axis_tkeep, s_axis_tlast, s_axis_tid, s_axis_tdest, s_axis_tuser} <= v[84:64];
		s_axis_tdata <= v[63:0];
		inject_sbit <= sb;
		inject_dbit <= db;
		do @(posedge clk_sys); while (s_axis_tready !== 1'h1);
		s_axis_tvalid <= 1'h0;
		inject_sbit <= 1'h0;
		inject_dbit <= 1'h0;
	endtask
	// slow sink until n beats are in, bounded wait
	task automatic drain(int n);
		mode <= 2'h2;
		repeat (300) if (sink.got.size() < n) @(posedge clk_sys);
		mode <= 2'h0;
		chk("count", sink.got.size(), n);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// hang guard, far beyond the fewer than two hundred cycles the run needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		repeat (2) @(posedge clk_sys);
		chk("pe pin", prog_empty, 1'h1);
		rchk("ctrl", REG_CTRL, CTRL_RST);
		rchk("mask", REG_MASK, MASK_RST);
		rchk("thr", REG_THR, 33'h2C);
		rchk("unmapped", 8'h40, 33'h100000000);
		// fill store and output stage with the sink stalled, then offer one more
		for (int i = 0; i < 17; i++) push(i, 1'h0, 1'h0);
		@(posedge clk_sys);
		s_axis_tvalid <= 1'h1;
		repeat (4) @(posedge clk_sys);
		chk("full", {overflow, s_axis_tready, prog_full, prog_empty}, 4'h2);
		s_axis_tvalid <= 1'h0;
		rchk("stat full", REG_STAT, 33'hB0);
		drain(17);
		for (int i = 0; i < 17; i++) begin
			chk("beat", sink.got.pop_front(), exp_beat(i, 1'h0, 1'h0));
		end
		rchk("stat empty", REG_STAT, 33'h140);
		chk("irq masked", irq, 1'h0);
		// corrupted words leave with their flags
		apb(1'h1, REG_MASK, 32'h1);
		push(20, 1'h1, 1'h0);
		push(21, 1'h0, 1'h1);
		push(22, 1'h0, 1'h0);
		drain(3);
		chk("sbe", sink.got.pop_front(), exp_beat(20, 1'h1, 1'h0));
		w = sink.got.pop_front();
		chk("dbe", w[86:85], 2'h1);
		chk("clean", sink.got.pop_front(), exp_beat(22, 1'h0, 1'h0));
		chk("irq", irq, 1'h1);
		rchk("irq st", REG_IRQ, 33'hB);
		apb(1'h1, REG_IRQ, 32'hF);
		rchk("irq clr", REG_IRQ, 33'h0);
		chk("irq low", irq, 1'h0);
		// options off: injection ignored, flags clean, threshold flags held low
		apb(1'h1, REG_CTRL, 32'h0);
		push(23, 1'h1, 1'h0);
		drain(1);
		chk("ecc off", sink.got.pop_front(), exp_beat(23, 1'h0, 1'h0));
		chk("opts off", {prog_full, prog_empty}, 2'h0);
		// new thresholds only while reset is held
		rst <= 1'h1;
		prog_full_thresh <= 4'h5;
		prog_empty_thresh <= 4'h9;
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rchk("thr new", REG_THR, 33'h95);
		rchk("ctrl rst", REG_CTRL, CTRL_RST);
		report_and_stop();
	end
endmodule
